/* rtl/isc_pkg.sv */
// constants, register map and field layout of the slave clock-stretch block
// assumes a single 40 MHz clock and a byte-wide register port
//
// How it works
// (RULE1) with release bit clear, pull SCL low once it is seen low, then keep it
// (RULE2) never start a stretch during a high phase; wait for the master's low
// (RULE3) hold SCL low until release bit is set and others let go
// (RULE4) let go only while the bus is low, so high time is never cut
// (RULE5) mode 1001 redirects slave address location to the address mask
// (RULE6) software must set SCL and SDA pin directions once the port is on
// (RULE7) hardware clears the release bit, stretching until software sets it again
// (RULE8) interrupt flag is set on the ninth falling clock edge of each byte
// (RULE9) port disabled: both lines released, no bus activity
package isc_pkg;

    // ****************************************
    // register indices on the port
    // ****************************************
    localparam logic [3:0] ISC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] ISC_ADDR_STAT = 4'h1;
    localparam logic [3:0] ISC_ADDR_SADR = 4'h2;
    localparam logic [3:0] ISC_ADDR_IRQS = 4'h3;
    localparam logic [3:0] ISC_ADDR_IRQM = 4'h4;

    // ****************************************
    // port_control fields
    // ****************************************
    localparam int ISC_CTRL_WRITE_COLLISION = 7;
    localparam int ISC_CTRL_ROVF = 6;
    localparam int ISC_CTRL_EN = 5;
    localparam int ISC_CTRL_REL = 4;
    localparam int ISC_CTRL_MODE_HI = 3;

    // port_mode_select codes
    localparam logic [3:0] ISC_MODE_MASK = 4'h9;
    localparam logic [3:0] ISC_MODE_S7 = 4'h6;
    localparam logic [3:0] ISC_MODE_S10 = 4'h7;
    localparam logic [3:0] ISC_MODE_S7I = 4'he;
    localparam logic [3:0] ISC_MODE_S10I = 4'hf;

    // ****************************************
    // port_status fields
    // ****************************************
    localparam int ISC_STAT_SMP = 7;
    localparam int ISC_STAT_CKE = 6;
    localparam int ISC_STAT_STOP = 4;
    localparam int ISC_STAT_START = 3;

    // interrupt status and mask bits
    localparam int ISC_IRQ_BYTE = 0;
    localparam int ISC_IRQ_START = 1;
    localparam int ISC_IRQ_STOP = 2;

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0] ISC_CTRL_RST = 8'h00;
    localparam logic [7:0] ISC_STAT_RST = 8'h00;
    localparam logic [7:0] ISC_SADR_RST = 8'h00;
    localparam logic [7:0] ISC_MASK_RST = 8'hff;
    localparam logic [7:0] ISC_ZERO8 = 8'h00;
    localparam logic [2:0] ISC_IRQ_RST = 3'h0;
    localparam logic [3:0] ISC_CLK_PER_BYTE = 4'h9;
    localparam logic [3:0] ISC_CNT_ONE = 4'h1;
    localparam logic [3:0] ISC_CNT_ZERO = 4'h0;

    typedef enum logic [1:0] {
        ISC_FREE = 2'b01,
        ISC_HOLD = 2'b10
    } isc_scl_e;

endpackage : isc_pkg

/* rtl/isc_line_sample.sv */
// samples one bus line and reports its level and edges
// assumes the line is already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module isc_line_sample
    import isc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic line,
    output logic level,
    output logic rise,
    output logic fall
);

    logic level_r;
    logic prev_r;
    logic level_nxt;
    logic prev_nxt;

    always_comb
    begin
        level_nxt = line;
        prev_nxt = level_r;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            level_r <= 1'b1;
            prev_r <= 1'b1;
        end
        else if (ce)
        begin
            level_r <= level_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign level = level_r;
    assign rise = level_r & ~prev_r;
    assign fall = ~level_r & prev_r;

endmodule : isc_line_sample
`default_nettype wire

/* rtl/isc_stretch_ctrl.sv */
// control, status and clock-stretch logic of the slave serial port
// assumes synchronous SCL/SDA inputs and an external wired-AND bus
`timescale 1ns/10ps
`default_nettype none
module isc_stretch_ctrl
    import isc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    // ****************************************
    // line sampling
    // ****************************************
    logic scl_s, scl_fall, sda_rise, sda_fall;

    isc_line_sample u_scl (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .line(scl_in),
        .level(scl_s),
        .rise(),
        .fall(scl_fall)
    );

    isc_line_sample u_sda (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .line(sda_in),
        .level(),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // ****************************************
    // state
    // ****************************************
    logic [7:0] ctrl_r, ctrl_nxt, stat_r, stat_nxt;
    logic [7:0] sadr_r, sadr_nxt, mask_r, mask_nxt;
    logic [2:0] irqs_r, irqs_nxt, irqm_r, irqm_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    isc_scl_e scl_st_r, scl_st_nxt;
    logic oe_r, oe_nxt;

    logic en, rel, mask_sel, start_evt, stop_evt, byte_evt, slave_mode;
    logic [2:0] evts;

    always_comb
    begin
        en = ctrl_r[ISC_CTRL_EN];
        rel = ctrl_r[ISC_CTRL_REL];
        mask_sel = ctrl_r[ISC_CTRL_MODE_HI -: 4] == ISC_MODE_MASK; // RULE5
        slave_mode = ctrl_r[ISC_CTRL_MODE_HI -: 4] inside
            {ISC_MODE_S7, ISC_MODE_S10, ISC_MODE_S7I, ISC_MODE_S10I};
        start_evt = en && sda_fall && scl_s;
        stop_evt = en && sda_rise && scl_s;
        byte_evt = en && scl_fall && cnt_r == ISC_CLK_PER_BYTE;
        evts = {stop_evt, start_evt, byte_evt};
    end

    // ****************************************
    // bit counter and registers
    // ****************************************
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (!en || start_evt || stop_evt)
            cnt_nxt = ISC_CNT_ZERO;
        else if (byte_evt)
            cnt_nxt = ISC_CNT_ONE;
        else if (scl_fall)
            cnt_nxt = 4'(cnt_r + ISC_CNT_ONE);

        ctrl_nxt = ctrl_r;
        stat_nxt = stat_r;
        sadr_nxt = sadr_r;
        mask_nxt = mask_r;
        irqm_nxt = irqm_r;
        if (wr)
        begin
            unique case (addr)
                ISC_ADDR_CTRL: ctrl_nxt = wdata;
                ISC_ADDR_STAT:
                begin
                    stat_nxt[ISC_STAT_SMP] = wdata[ISC_STAT_SMP];
                    stat_nxt[ISC_STAT_CKE] = wdata[ISC_STAT_CKE];
                end
                ISC_ADDR_SADR:
                begin
                    if (mask_sel)
                        mask_nxt = wdata; // RULE5
                    else
                        sadr_nxt = wdata;
                end
                ISC_ADDR_IRQM: irqm_nxt = wdata[2:0];
                default: ;
            endcase
        end
        // hardware clear of the release bit wins over a software set
        if (byte_evt && slave_mode)
            ctrl_nxt[ISC_CTRL_REL] = 1'b0; // RULE7
        if (!en)
        begin
            stat_nxt[ISC_STAT_START] = 1'b0;
            stat_nxt[ISC_STAT_STOP] = 1'b0;
        end
        else if (start_evt)
        begin
            stat_nxt[ISC_STAT_START] = 1'b1;
            stat_nxt[ISC_STAT_STOP] = 1'b0;
        end
        else if (stop_evt)
        begin
            stat_nxt[ISC_STAT_START] = 1'b0;
            stat_nxt[ISC_STAT_STOP] = 1'b1;
        end

        // write-one-to-clear, a new event wins
        irqs_nxt = irqs_r;
        if (wr && addr == ISC_ADDR_IRQS)
            irqs_nxt = irqs_r & ~wdata[2:0];
        irqs_nxt = irqs_nxt | evts; // RULE8
        irq_nxt = |(irqs_nxt & irqm_nxt);

        rdata_nxt = ISC_ZERO8;
        if (rd)
        begin
            unique case (addr)
                ISC_ADDR_CTRL: rdata_nxt = ctrl_r;
                ISC_ADDR_STAT: rdata_nxt = stat_r;
                ISC_ADDR_SADR: rdata_nxt = mask_sel ? mask_r : sadr_r; // RULE5
                ISC_ADDR_IRQS: rdata_nxt = {5'h00, irqs_r};
                ISC_ADDR_IRQM: rdata_nxt = {5'h00, irqm_r};
                default: rdata_nxt = ISC_ZERO8;
            endcase
        end
    end

    // ****************************************
    // clock stretch
    // ****************************************
    always_comb
    begin
        scl_st_nxt = scl_st_r;
        unique case (scl_st_r)
            ISC_FREE:
                if (en && !rel && !scl_s)
                    scl_st_nxt = ISC_HOLD; // RULE1 RULE2
            ISC_HOLD:
                if (!en || rel)
                    scl_st_nxt = ISC_FREE; // RULE3 RULE4 RULE9
            default: scl_st_nxt = ISC_FREE;
        endcase
        oe_nxt = scl_st_nxt == ISC_HOLD;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_r <= ISC_CTRL_RST;
            stat_r <= ISC_STAT_RST;
            sadr_r <= ISC_SADR_RST;
            mask_r <= ISC_MASK_RST;
            irqs_r <= ISC_IRQ_RST;
            irqm_r <= ISC_IRQ_RST;
            cnt_r <= ISC_CNT_ZERO;
            rdata_r <= ISC_ZERO8;
            irq_r <= 1'b0;
            scl_st_r <= ISC_FREE;
            oe_r <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            sadr_r <= sadr_nxt;
            mask_r <= mask_nxt;
            irqs_r <= irqs_nxt;
            irqm_r <= irqm_nxt;
            cnt_r <= cnt_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            scl_st_r <= scl_st_nxt;
            oe_r <= oe_nxt;
        end
    end

    // the port only ever pulls low; SDA is left to the byte logic outside
    assign rdata = rdata_r;
    assign irq = irq_r;
    assign scl_oe = oe_r;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign sda_oe = 1'b0; // RULE9

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_hold_when_low;
        ce && en && !rel && !scl_s |=> scl_oe;
    endproperty
    a_hold_when_low: assert property (p_hold_when_low) else $error("no hold on low scl"); // RULE1

    property p_no_high_start;
        $rose(scl_oe) |-> !$past(scl_s);
    endproperty
    a_no_high_start: assert property (p_no_high_start) else $error("stretch began high"); // RULE2

    property p_keep_hold;
        scl_oe && ce && en && !rel |=> scl_oe;
    endproperty
    a_keep_hold: assert property (p_keep_hold) else $error("hold dropped early"); // RULE3

    property p_release_cause;
        $fell(scl_oe) |-> $past(rel || !en);
    endproperty
    a_release_cause: assert property (p_release_cause) else $error("release w/o cause"); // RULE4

    property p_mask_read;
        ce && rd && addr == ISC_ADDR_SADR && mask_sel |=> rdata == $past(mask_r);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask not read"); // RULE5

    property p_hw_clear;
        ce && byte_evt && slave_mode |=> !ctrl_r[ISC_CTRL_REL];
    endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("release not cleared"); // RULE7

    property p_byte_flag;
        ce && byte_evt |=> irqs_r[ISC_IRQ_BYTE] ##0 cnt_r == ISC_CNT_ONE;
    endproperty
    a_byte_flag: assert property (p_byte_flag) else $error("byte flag missing"); // RULE8

    property p_off_quiet;
        ce && !en |=> !scl_oe && cnt_r == ISC_CNT_ZERO;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("active while off"); // RULE9

endmodule : isc_stretch_ctrl
`default_nettype wire

/* tb/isc_master_model.sv */
// bus master model: pulls SCL and SDA low through open-drain drivers
// assumes the bench forms the wired-AND level of SCL and feeds it back
`timescale 1ns/10ps
`default_nettype none
module isc_master_model (
    input wire logic clk,
    input wire logic scl,
    output logic scl_pull,
    output logic sda_pull
);
    // ****************************************
    // line control tasks
    // ****************************************
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    task automatic lines(input logic s, input logic d);
        @(posedge clk);
        scl_pull <= s;
        sda_pull <= d;
        wait_cyc(6);
    endtask : lines

    // start: sda falls while scl high, then scl goes low
    task automatic start();
        lines(1'b0, 1'b1);
        lines(1'b1, 1'b1);
    endtask : start

    task automatic pulse();
        @(posedge clk);
        scl_pull <= 1'b0;
        // clock sync: a stretching slave delays the high phase; the bench watchdog bounds it
        while (scl !== 1'b1)
        begin
            @(posedge clk);
        end
        wait_cyc(4);
        scl_pull <= 1'b1;
        wait_cyc(6);
    endtask : pulse
endmodule : isc_master_model
`default_nettype wire

/* tb/i2c_slave_clock_stretch_ctrl_tb_top.sv */
// testbench: register and clock-stretch scenarios of the slave port
// assumes the master model and a pulled-up wired-AND bus
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_clock_stretch_ctrl_tb_top
    import isc_pkg::*;
;
    localparam logic [7:0] C_HOLD = {3'b001, 1'b0, ISC_MODE_S7};
    localparam logic [7:0] C_REL = {3'b001, 1'b1, ISC_MODE_S7};
    localparam logic [7:0] C_OFF = {3'b000, 1'b0, ISC_MODE_S7};
    localparam logic [7:0] C_MSK = {3'b001, 1'b1, ISC_MODE_MASK};
    logic clk, reset_n, ce, wr, rd, irq, scl_out, scl_oe, sda_out, sda_oe;
    logic scl_pull, sda_pull;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    wire logic scl, sda;
    int mismatches, n_tests;

    assign scl = ~(scl_pull | (scl_oe & ~scl_out));
    assign sda = ~(sda_pull | (sda_oe & ~sda_out));

    isc_stretch_ctrl dut (.clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe));
    isc_master_model m (.clk(clk), .scl(scl), .scl_pull(scl_pull), .sda_pull(sda_pull));

    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        reset_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        ce = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        mismatches = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 6; a++)
        begin
            rd_reg(4'(a), d);
            chk("reset value", d, 8'h00);
        end
        // only the two software bits of status are writable
        wr_reg(ISC_ADDR_STAT, 8'hff);
        rd_reg(ISC_ADDR_STAT, d);
        chk("status sw bits", d, 8'hc0);
        wr_reg(ISC_ADDR_SADR, 8'h5a);
        wr_reg(ISC_ADDR_CTRL, C_MSK);
        rd_reg(ISC_ADDR_SADR, d);
        chk("mask reset", d, ISC_MASK_RST);
        wr_reg(ISC_ADDR_SADR, 8'h3c);
        rd_reg(ISC_ADDR_SADR, d);
        chk("mask", d, 8'h3c);
        step(1);
        chk("rdata idle", rdata, 8'h00);
        wr_reg(ISC_ADDR_CTRL, C_REL);
        rd_reg(ISC_ADDR_SADR, d);
        chk("slave addr", d, 8'h5a);
        // stretch with release clear
        wr_reg(ISC_ADDR_CTRL, C_HOLD);
        step(10);
        chk("oe scl high", {7'h00, scl_oe}, 8'h00);
        m.lines(1'b1, 1'b0);
        chk("oe after low", {7'h00, scl_oe}, 8'h01);
        m.lines(1'b0, 1'b0);
        step(1);
        chk("scl held", {7'h00, scl}, 8'h00);
        wr_reg(ISC_ADDR_CTRL, C_REL);
        step(3);
        chk("scl freed", {7'h00, scl}, 8'h01);
        // one byte: nine clocks
        wr_reg(ISC_ADDR_IRQM, 8'h01);
        // clock enable low: a write must not be taken
        ce <= 1'b0;
        wr_reg(ISC_ADDR_IRQM, 8'h07);
        ce <= 1'b1;
        rd_reg(ISC_ADDR_IRQM, d);
        chk("frozen write", d, 8'h01);
        m.start();
        repeat (8) m.pulse();
        step(1);
        chk("irq before 9th", {7'h00, irq}, 8'h00);
        m.pulse();
        step(1);
        chk("irq 9th", {7'h00, irq}, 8'h01);
        rd_reg(ISC_ADDR_IRQS, d);
        chk("irq status", d, 8'h03);
        rd_reg(ISC_ADDR_CTRL, d);
        chk("release cleared", d, C_HOLD);
        rd_reg(ISC_ADDR_STAT, d);
        chk("start seen", d, 8'hc8);
        m.lines(1'b0, 1'b1);
        step(1);
        chk("auto stretch", {7'h00, scl}, 8'h00);
        wr_reg(ISC_ADDR_IRQS, 8'h03);
        step(2);
        chk("irq cleared", {7'h00, irq}, 8'h00);
        wr_reg(ISC_ADDR_CTRL, C_REL);
        step(3);
        chk("scl after set", {7'h00, scl}, 8'h01);
        // stop: sda released while scl high
        m.lines(1'b0, 1'b0);
        rd_reg(ISC_ADDR_IRQS, d);
        chk("stop event", d, 8'h04);
        rd_reg(ISC_ADDR_STAT, d);
        chk("stop seen", d, 8'hd0);
        wr_reg(ISC_ADDR_IRQS, 8'h04);
        // disabled port
        wr_reg(ISC_ADDR_CTRL, C_OFF);
        m.lines(1'b0, 1'b0);
        m.start();
        step(1);
        chk("oe disabled", {6'h00, scl_oe, sda_oe}, 8'h00);
        chk("pin levels", {6'h00, scl_out, sda_out}, 8'h00);
        rd_reg(ISC_ADDR_IRQS, d);
        chk("no events", d, 8'h00);
        rd_reg(ISC_ADDR_STAT, d);
        chk("status off", d, 8'hc0);
        close_out();
    end
endmodule : i2c_slave_clock_stretch_ctrl_tb_top
`default_nettype wire
